// File: design/aps_pin_strap.sv
// pin strap capture, shared pin duty, gpio selector and host register port
`timescale 1ns/1ps
module aps_pin_strap
  import aps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [AXI_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // pins from outside
  input wire logic system_reset_input,
  input wire logic oscillator_input,
  input wire logic emphasis_fs_monitor_pin_in,
  output logic emphasis_fs_monitor_pin_out,
  output logic emphasis_fs_monitor_pin_oe_b,
  input wire logic channel_status_pin_in,
  output logic channel_status_pin_out,
  output logic channel_status_pin_oe_b,
  input wire logic clock_switch_window_pin_in,
  output logic clock_switch_window_pin_out,
  output logic clock_switch_window_pin_oe_b,
  input wire logic interrupt_pin_in,
  output logic interrupt_pin_out,
  output logic interrupt_pin_oe_b,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe_b,
  input wire logic host_chip_enable,
  input wire logic host_serial_clock,
  input wire logic host_write_in,
  output logic host_read_out,
  output logic host_read_oe_b,
  // receiver core on this clock
  input wire logic emphasis_in,
  input wire logic professional_format_in,
  input wire logic [7:0] fs_khz_in,
  input wire logic fs_monitor_in,
  input wire logic non_pcm_bit_in,
  input wire logic clock_switch_busy_in,
  input wire logic irq_level_in,
  input wire logic pll_lock_fail_in,
  input wire logic data_error_in,
  input wire logic sync_pattern_found_in,
  input wire logic serial_data_in,
  input wire logic lr_clock_in,
  input wire logic bit_clock_in,
  input wire logic master_clock_in,
  // outputs to pins and core
  output logic serial_data_out,
  output logic lr_clock_out,
  output logic bit_clock_out,
  output logic master_clock_out,
  output logic oscillator_clock_output,
  output logic lock_or_data_error_flag,
  output logic stream_detect,
  output logic [1:0] format_sel,
  output logic [1:0] secondary_bck_sel,
  output logic [1:0] secondary_lr_sel,
  output logic [2:0] rx_select,
  output logic [1:0] chip_addr,
  output logic master_mode,
  output logic gpio_dir_in
);

  // three-stage pin synchroniser and agreed level
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1, sync2, sync3, pin_lvl;
  wire [NSYNC-1:0] agree = ~(sync2 ^ sync3);
  wire [NSYNC-1:0] next_pin_lvl = (agree & sync3) | (~agree & pin_lvl);
  assign pin_raw = {oscillator_input, host_write_in, host_serial_clock, host_chip_enable, gpio_in,
                    interrupt_pin_in, clock_switch_window_pin_in, channel_status_pin_in,
                    emphasis_fs_monitor_pin_in, system_reset_input};

  // sync1 feeds only sync2, so no logic sees a metastable level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_lvl <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_lvl <= next_pin_lvl;
    end
  end

  // device held in reset by its pin
  wire in_reset = ~pin_lvl[PIN_SYSRST];
  wire [3:0] gpio_lvl = pin_lvl[PIN_GPIO_LO +: 4];

  // software registers
  logic [31:0] ctrl;
  logic [HOST_DW-1:0] cmd_mem [0:(1<<HOST_AW)-1];
  logic [HOST_AW-1:0] cmd_sel;
  logic [7:0] fs_report;
  wire mon_sel = ctrl[CTRL_MON_SEL];
  wire sel_en = ctrl[CTRL_SEL_EN];

  // strap capture: sampled while held, frozen from release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chip_addr <= 2'h0;
      master_mode <= 1'b0;
      gpio_dir_in <= 1'b0;
    end else if (in_reset) begin
      chip_addr <= {pin_lvl[PIN_MON], pin_lvl[PIN_CS]};
      master_mode <= pin_lvl[PIN_CLOCK_SWITCH_WINDOW_PIN];
      gpio_dir_in <= pin_lvl[PIN_INT];
    end
  end

  // pin duty after release; consumer format only carries emphasis
  wire emph_ok = emphasis_in & ~professional_format_in;
  wire mon_next = mon_sel ? fs_monitor_in : emph_ok;
  wire gpio_as_sel = gpio_dir_in & sel_en;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      emphasis_fs_monitor_pin_oe_b <= 1'b1;
      channel_status_pin_oe_b <= 1'b1;
      clock_switch_window_pin_oe_b <= 1'b1;
      interrupt_pin_oe_b <= 1'b1;
      gpio_oe_b <= 4'hF;
      emphasis_fs_monitor_pin_out <= 1'b0;
      channel_status_pin_out <= 1'b0;
      clock_switch_window_pin_out <= 1'b0;
      interrupt_pin_out <= 1'b0;
      gpio_out <= 4'h0;
    end else begin
      // drive only once straps are frozen
      emphasis_fs_monitor_pin_oe_b <= in_reset;
      channel_status_pin_oe_b <= in_reset;
      clock_switch_window_pin_oe_b <= in_reset;
      interrupt_pin_oe_b <= in_reset;
      gpio_oe_b <= {4{in_reset | gpio_dir_in}};
      emphasis_fs_monitor_pin_out <= mon_next;
      channel_status_pin_out <= non_pcm_bit_in;
      clock_switch_window_pin_out <= clock_switch_busy_in;
      interrupt_pin_out <= irq_level_in;
      gpio_out <= ctrl[CTRL_GPO_LO +: 4];
    end
  end

  // routed audio outputs and status outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      serial_data_out <= 1'b0;
      lr_clock_out <= 1'b0;
      bit_clock_out <= 1'b0;
      master_clock_out <= 1'b0;
      oscillator_clock_output <= 1'b0;
      lock_or_data_error_flag <= 1'b0;
      fs_report <= 8'h00;
    end else begin
      // gpio0..3 to data, lr, bit, master
      serial_data_out <= gpio_as_sel ? gpio_lvl[0] : serial_data_in;
      lr_clock_out <= gpio_as_sel ? gpio_lvl[1] : lr_clock_in;
      bit_clock_out <= gpio_as_sel ? gpio_lvl[2] : bit_clock_in;
      master_clock_out <= gpio_as_sel ? gpio_lvl[3] : master_clock_in;
      // oscillator clock on its own output
      oscillator_clock_output <= pin_lvl[PIN_OSC];
      lock_or_data_error_flag <= pll_lock_fail_in | data_error_in;
      fs_report <= (fs_khz_in >= FS_MIN_KHZ && fs_khz_in <= FS_MAX_KHZ) ? fs_khz_in : 8'h00;
    end
  end

  // axi write path: address and data taken in either order
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_full, w_full;
  wire aw_hand = s_awvalid & s_awready;
  wire w_hand = s_wvalid & s_wready;
  wire do_write = aw_full & w_full & ~s_bvalid;
  wire next_aw_full = ~do_write & (aw_full | aw_hand);
  wire next_w_full = ~do_write & (w_full | w_hand);
  wire next_bvalid = do_write | (s_bvalid & ~s_bready);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] ctrl_merge = (ctrl & ~wmask) | (w_data & wmask);
  wire hit_ctrl = aw_addr == OFS_CTRL;
  wire hit_stat = aw_addr == OFS_STAT;
  wire hit_cmd = aw_addr == OFS_CMD;
  wire wr_mapped = hit_ctrl | hit_stat | hit_cmd | (aw_addr == OFS_FS);
  wire fmt_ok = ctrl_merge[CTRL_FMT_LO +: 2] == FMT_LEFT || ctrl_merge[CTRL_FMT_LO +: 2] == FMT_I2S;
  wire rx_ok = ctrl_merge[CTRL_RX_LO +: 3] <= RX_LAST;
  wire [31:0] ctrl_fmt = fmt_ok ? ctrl_merge : {ctrl_merge[31:CTRL_FMT_LO+2], ctrl[CTRL_FMT_LO +: 2],
                                                ctrl_merge[CTRL_FMT_LO-1:0]};
  wire [31:0] ctrl_new = rx_ok ? ctrl_fmt : {ctrl_fmt[31:CTRL_RX_LO+3], ctrl[CTRL_RX_LO +: 3],
                                             ctrl_fmt[CTRL_RX_LO-1:0]};
  wire clr_detect = do_write & hit_stat & w_strb[0] & w_data[STAT_DETECT];

  // write channel handshake and response
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      // one write at a time: ready drops until the response is taken
      s_awready <= ~next_aw_full & ~next_bvalid;
      s_wready <= ~next_w_full & ~next_bvalid;
      s_bvalid <= next_bvalid;
      if (aw_hand) begin
        aw_addr <= s_awaddr;
      end
      if (w_hand) begin
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (do_write) begin
        s_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // control register; fields feed the clock and format outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      format_sel <= FMT_LEFT;
      secondary_bck_sel <= SECONDARY_BIT_CLOCK_16FS;
      secondary_lr_sel <= SLR_QUARTER;
      rx_select <= 3'h0;
    end else begin
      if (do_write && hit_ctrl) begin
        ctrl <= ctrl_new;
      end
      format_sel <= ctrl[CTRL_FMT_LO +: 2];
      // secondary rates only, no source of its own
      // 16fs to 128fs and quarter to double fs codes offered
      secondary_bck_sel <= ctrl[CTRL_SECONDARY_BIT_CLOCK_LO +: 2];
      secondary_lr_sel <= ctrl[CTRL_SLR_LO +: 2];
      rx_select <= ctrl[CTRL_RX_LO +: 3];
    end
  end

  // sticky stream flag, a new find beats the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stream_detect <= 1'b0;
    end else if (sync_pattern_found_in) begin
      stream_detect <= 1'b1;
    end else if (clr_detect) begin
      stream_detect <= 1'b0;
    end
  end

  // host serial port: read flag, address, data, msb first
  logic host_ce_q, host_cl_q;
  logic [3:0] host_cnt;
  logic [HOST_AW+HOST_DW-1:0] host_shift;
  logic host_reading;
  logic [HOST_DW-1:0] host_out;
  wire host_ce = pin_lvl[PIN_CE];
  wire host_cl = pin_lvl[PIN_CL];
  wire cl_rise = host_ce & host_cl & ~host_cl_q;
  wire cl_fall = host_ce & ~host_cl & host_cl_q;
  wire [HOST_AW+HOST_DW-1:0] next_shift = {host_shift[HOST_AW+HOST_DW-2:0], pin_lvl[PIN_DI]};
  wire addr_done = cl_rise & (host_cnt == HOST_ADDR_DONE - 4'h1);
  wire host_wr = cl_rise & ~host_reading & (host_cnt == HOST_FRAME_DONE - 4'h1);
  wire [HOST_AW-1:0] host_addr = next_shift[HOST_AW-1:0];
  wire axi_cmd = do_write & hit_cmd & w_strb[1];
  wire [HOST_AW-1:0] axi_cmd_addr = w_data[HOST_AW-1:0];

  // frame counter, read shift out on falling serial clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_ce_q <= 1'b0;
      host_cl_q <= 1'b0;
      host_cnt <= 4'h0;
      host_shift <= '0;
      host_reading <= 1'b0;
      host_out <= '0;
      host_read_out <= 1'b0;
      host_read_oe_b <= 1'b1;
    end else begin
      host_ce_q <= host_ce;
      host_cl_q <= host_cl;
      if (!host_ce) begin
        host_cnt <= 4'h0;
        host_reading <= 1'b0;
      end else if (cl_rise) begin
        host_cnt <= (host_cnt == HOST_FRAME_DONE) ? host_cnt : host_cnt + 4'h1;
        host_shift <= next_shift;
        if (host_cnt == 4'h0) begin
          host_reading <= pin_lvl[PIN_DI];
        end
        if (addr_done) begin
          host_out <= cmd_mem[host_addr];
        end
      end else if (cl_fall && host_reading && host_cnt >= HOST_ADDR_DONE) begin
        host_read_out <= host_out[HOST_DW-1];
        host_out <= {host_out[HOST_DW-2:0], 1'b0};
      end
      // pin released unless a read frame is open
      host_read_oe_b <= ~(host_ce & host_reading);
    end
  end

  // sixteen command words of eight bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_sel <= '0;
    end else if (axi_cmd) begin
      cmd_sel <= axi_cmd_addr;
    end
  end
  // software write takes priority over a host frame in the same cycle
  always_ff @(posedge clk) begin
    if (axi_cmd) begin
      cmd_mem[axi_cmd_addr] <= w_data[15:8];
    end else if (host_wr) begin
      cmd_mem[host_shift[HOST_DW+HOST_AW-2:HOST_DW-1]] <= next_shift[HOST_DW-1:0];
    end
  end

  // axi read path, answer one cycle after the address is taken
  wire ar_hand = s_arvalid & s_arready;
  wire next_rvalid = ar_hand | (s_rvalid & ~s_rready);
  wire [31:0] stat_word = {20'h0, gpio_lvl, 2'h0, stream_detect, lock_or_data_error_flag,
                           gpio_dir_in, master_mode, chip_addr};
  wire [31:0] cmd_word = {16'h0, cmd_mem[cmd_sel], 4'h0, cmd_sel};
  wire rd_ctrl = s_araddr == OFS_CTRL;
  wire rd_stat = s_araddr == OFS_STAT;
  wire rd_fs = s_araddr == OFS_FS;
  wire rd_cmd = s_araddr == OFS_CMD;
  wire rd_mapped = rd_ctrl | rd_stat | rd_fs | rd_cmd;
  wire [31:0] rd_word = rd_ctrl ? ctrl : rd_stat ? stat_word : rd_fs ? {24'h0, fs_report} :
                        rd_cmd ? cmd_word : 32'h0000_0000;

  // read channel registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else begin
      s_arready <= ~next_rvalid;
      s_rvalid <= next_rvalid;
      if (ar_hand) begin
        s_rdata <= rd_word;
        s_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // checks on the block's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_addr_capture;
    in_reset |=> chip_addr == $past({pin_lvl[PIN_MON], pin_lvl[PIN_CS]});
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("chip address not sampled");
  property p_master_capture;
    in_reset |=> master_mode == $past(pin_lvl[PIN_CLOCK_SWITCH_WINDOW_PIN]);
  endproperty
  a_master_capture: assert property (p_master_capture) else $error("master strap not sampled");
  property p_dir_hold;
    !in_reset ##1 !in_reset |-> $stable(gpio_dir_in) && $stable(chip_addr);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("strap changed after release");
  property p_pins_released;
    in_reset |=> emphasis_fs_monitor_pin_oe_b && channel_status_pin_oe_b && interrupt_pin_oe_b;
  endproperty
  a_pins_released: assert property (p_pins_released) else $error("shared pin driven in reset");
  property p_switch_window;
    !in_reset |=> clock_switch_window_pin_out == $past(clock_switch_busy_in) && !clock_switch_window_pin_oe_b;
  endproperty
  a_switch_window: assert property (p_switch_window) else $error("switch window pin wrong");
  property p_selector;
    gpio_as_sel |=> serial_data_out == $past(gpio_lvl[0]) && master_clock_out == $past(gpio_lvl[3]);
  endproperty
  a_selector: assert property (p_selector) else $error("selector routing wrong");
  property p_format;
    format_sel == FMT_LEFT || format_sel == FMT_I2S;
  endproperty
  a_format: assert property (p_format) else $error("illegal output format");
  property p_fs_window;
    fs_report == 8'h00 || (fs_report >= FS_MIN_KHZ && fs_report <= FS_MAX_KHZ);
  endproperty
  a_fs_window: assert property (p_fs_window) else $error("fs report out of window");
  property p_error_flag;
    (pll_lock_fail_in || data_error_in) |=> lock_or_data_error_flag;
  endproperty
  a_error_flag: assert property (p_error_flag) else $error("error flag missed");
  property p_read_drive;
    !host_read_oe_b |-> $past(host_reading) && $past(host_ce);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read pin driven outside read");
  property p_detect_sticky;
    sync_pattern_found_in |=> stream_detect [*2];
  endproperty
  a_detect_sticky: assert property (p_detect_sticky) else $error("detect flag lost");

  c_release: cover property (in_reset ##1 !in_reset);
  c_axi_write: cover property (do_write ##1 s_bvalid && s_bready);
  c_host_read: cover property (addr_done && host_reading);
  c_selector: cover property (gpio_as_sel);

endmodule

// File: design/aps_pkg.sv
// constants shared by the audio receiver pin strap and pin function block
package aps_pkg;
  // clock rate of the block
  localparam int unsigned CLK_HZ = 32'd20_000_000;
  // axi4-lite geometry and answers
  localparam int unsigned AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_FS = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  // control register fields
  localparam int unsigned CTRL_MON_SEL = 0;
  localparam int unsigned CTRL_FMT_LO = 1;
  localparam int unsigned CTRL_SEL_EN = 3;
  localparam int unsigned CTRL_GPO_LO = 4;
  localparam int unsigned CTRL_SECONDARY_BIT_CLOCK_LO = 8;
  localparam int unsigned CTRL_SLR_LO = 10;
  localparam int unsigned CTRL_RX_LO = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // status register fields
  localparam int unsigned STAT_ADDR_LO = 0;
  localparam int unsigned STAT_MASTER = 2;
  localparam int unsigned STAT_GPIO_IN = 3;
  localparam int unsigned STAT_ERR = 4;
  localparam int unsigned STAT_DETECT = 5;
  localparam int unsigned STAT_GPI_LO = 8;
  // serial audio formats; right-justified has no code
  localparam logic [1:0] FMT_LEFT = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  // secondary bit clock rate codes
  localparam logic [1:0] SECONDARY_BIT_CLOCK_16FS = 2'h0;
  localparam logic [1:0] SECONDARY_BIT_CLOCK_32FS = 2'h1;
  localparam logic [1:0] SECONDARY_BIT_CLOCK_64FS = 2'h2;
  localparam logic [1:0] SECONDARY_BIT_CLOCK_128FS = 2'h3;
  // secondary lr clock rate codes
  localparam logic [1:0] SLR_QUARTER = 2'h0;
  localparam logic [1:0] SLR_HALF = 2'h1;
  localparam logic [1:0] SLR_ONE = 2'h2;
  localparam logic [1:0] SLR_DOUBLE = 2'h3;
  // receive inputs: one coaxial plus six optical
  localparam logic [2:0] RX_LAST = 3'h6;
  // computed sampling rate window in khz
  localparam logic [7:0] FS_MIN_KHZ = 8'h20;
  localparam logic [7:0] FS_MAX_KHZ = 8'hC0;
  // host serial frame: read flag, 4 address bits, 8 data bits
  localparam int unsigned HOST_AW = 4;
  localparam int unsigned HOST_DW = 8;
  localparam logic [3:0] HOST_ADDR_DONE = 4'h5;
  localparam logic [3:0] HOST_FRAME_DONE = 4'hD;
  // synchroniser bank bit positions
  localparam int unsigned NSYNC = 13;
  localparam int unsigned PIN_SYSRST = 0;
  localparam int unsigned PIN_MON = 1;
  localparam int unsigned PIN_CS = 2;
  localparam int unsigned PIN_CLOCK_SWITCH_WINDOW_PIN = 3;
  localparam int unsigned PIN_INT = 4;
  localparam int unsigned PIN_GPIO_LO = 5;
  localparam int unsigned PIN_CE = 9;
  localparam int unsigned PIN_CL = 10;
  localparam int unsigned PIN_DI = 11;
  localparam int unsigned PIN_OSC = 12;
endpackage

// File: verif/aps_host_mcu.sv
// host microcontroller model on the serial register port
`timescale 1ns/1ps
module aps_host_mcu (
  input wire logic clk,
  output logic host_chip_enable,
  output logic host_serial_clock,
  output logic host_write_in,
  input wire logic host_read_out,
  input wire logic host_read_oe_b
);
  // half period kept well above the pin synchroniser delay
  localparam int H = 8;
  // lines idle low until a frame starts
  initial begin
    host_chip_enable = 1'h0;
    host_serial_clock = 1'h0;
    host_write_in = 1'h0;
  end
  // one frame: read flag, address, data, msb first
  // host drives enable, clock and write data
  task xfer(input logic [12:0] f, output logic [7:0] q, output logic oe_b);
    oe_b = 1'h0;
    @(posedge clk);
    host_chip_enable <= 1'h1;
    for (int i = 12; i >= 0; i--) begin
      host_write_in <= f[i];
      repeat (H) @(posedge clk);
      // read bits are caught late in the low half, after the falling shift
      if (i < 8) begin
        // a released line reads as the inverse, so a missing drive shows up
        q[i] = host_read_oe_b ? ~host_read_out : host_read_out;
        oe_b = oe_b | host_read_oe_b;
      end
      host_serial_clock <= 1'h1;
      repeat (H) @(posedge clk);
      host_serial_clock <= 1'h0;
    end
    host_chip_enable <= 1'h0;
    repeat (H) @(posedge clk);
  endtask
endmodule

// File: verif/tb_aps_pin_strap.sv
// self-checking bench for the pin strap and pin function block
`timescale 1ns/1ps
module tb_aps_pin_strap import aps_pkg::*; ();
  logic clk, rst_b, system_reset_input, oscillator_input, sync_pattern_found_in;
  logic [7:0] s_awaddr, s_araddr, fs_khz_in, q;
  logic [31:0] s_wdata, s_rdata, x, rd, ctrl;
  logic [3:0] s_wstrb, gpio_in, gpio_out, gpio_oe_b, g, st;
  logic [1:0] s_bresp, s_rresp, chip_addr, format_sel, secondary_bck_sel, secondary_lr_sel, rr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic emphasis_fs_monitor_pin_in, emphasis_fs_monitor_pin_out, emphasis_fs_monitor_pin_oe_b;
  logic channel_status_pin_in, channel_status_pin_out, channel_status_pin_oe_b;
  logic clock_switch_window_pin_in, clock_switch_window_pin_out, clock_switch_window_pin_oe_b;
  logic interrupt_pin_in, interrupt_pin_out, interrupt_pin_oe_b, oe, master_mode, gpio_dir_in;
  logic host_chip_enable, host_serial_clock, host_write_in, host_read_out, host_read_oe_b;
  logic emphasis_in, professional_format_in, fs_monitor_in, non_pcm_bit_in, clock_switch_busy_in, irq_level_in;
  logic pll_lock_fail_in, data_error_in, serial_data_in, lr_clock_in, bit_clock_in, master_clock_in;
  logic serial_data_out, lr_clock_out, bit_clock_out, master_clock_out, oscillator_clock_output;
  logic lock_or_data_error_flag, stream_detect;
  logic [2:0] rx_select;
  logic [11:0] cv;
  logic [7:0] bnd [4] = '{8'h1F, 8'h20, 8'hC0, 8'hC1};
  int n_mismatch, tests_run, n, i, k, fmt, rxm;
  // core inputs packed so one random word sets them all
  assign {master_clock_in, bit_clock_in, lr_clock_in, serial_data_in, data_error_in, pll_lock_fail_in,
    irq_level_in, clock_switch_busy_in, non_pcm_bit_in, fs_monitor_in, professional_format_in, emphasis_in} = cv;
  // shared pins: strap level shows only while the device lets go
  assign emphasis_fs_monitor_pin_in = emphasis_fs_monitor_pin_oe_b ? st[1] : emphasis_fs_monitor_pin_out;
  assign channel_status_pin_in = channel_status_pin_oe_b ? st[0] : channel_status_pin_out;
  assign clock_switch_window_pin_in = clock_switch_window_pin_oe_b ? st[2] : clock_switch_window_pin_out;
  assign interrupt_pin_in = interrupt_pin_oe_b ? st[3] : interrupt_pin_out;
  assign gpio_in = (gpio_oe_b & g) | (~gpio_oe_b & gpio_out);
  aps_pin_strap i_aps_pin_strap (.*);
  aps_host_mcu i_aps_host_mcu (.*);
  // 50 ns clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // one comparison, counted
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a spent wait bound ends the run
  task tmo(input int c);
    if (c >= 40) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  function logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // axi write: each channel released at its own handshake
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
      if (s_bvalid) break;
    end
    rr = s_bresp;
    s_bready <= 1'h0;
    tmo(n);
  endtask
  task axr(input logic [7:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
      if (s_rvalid) break;
    end
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'h0;
    tmo(n);
  endtask
  // main sequence
  initial begin
    x = 32'h65E3A9D7;
    {rst_b, system_reset_input, oscillator_input, sync_pattern_found_in} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {fs_khz_in, cv, g} = '0;
    s_wstrb = 4'hF;
    rd = xs();
    st = {1'h1, rd[2:0]};
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    repeat (10) @(posedge clk);
    system_reset_input <= 1'h1;
    for (n = 0; n < 40 && clock_switch_window_pin_oe_b !== 1'h0; n++) @(posedge clk);
    tmo(n);
    // strap drive flipped after release must not reach the latched values
    st <= ~st;
    repeat (4) @(posedge clk);
    chk("straps", {gpio_dir_in, master_mode, chip_addr}, 4'(~st));
    chk("pin_oe", {emphasis_fs_monitor_pin_oe_b, channel_status_pin_oe_b, interrupt_pin_oe_b}, 3'h0);
    axr(OFS_STAT);
    chk("stat", rd[3:0], 4'(~st));
    // every rate code; format 2, 3 and input 7 are refused
    for (k = 0; k < 4; k++) begin
      axw(OFS_CTRL, ((k + 4) << 12) | (k << 10) | (k << 8) | (k << 1));
      if (k < 2) fmt = k;
      if (k < 3) rxm = k + 4;
      repeat (2) @(posedge clk);
      chk("fmt", format_sel, fmt);
      chk("sec", {secondary_lr_sel, secondary_bck_sel}, {k[1:0], k[1:0]});
      chk("rx", rx_select, rxm);
    end
    // random core traffic, then with monitor select and gpio selector on
    for (i = 0; i < 24; i++) begin
      rd = xs();
      ctrl = (i < 12) ? 32'h0 : 32'hA9;
      if (i == 12) axw(OFS_CTRL, ctrl);
      cv <= rd[11:0];
      g <= rd[15:12];
      oscillator_input <= rd[16];
      fs_khz_in <= (i < 4) ? bnd[i] : rd[31:24];
      repeat (6) @(posedge clk);
      chk("mon", emphasis_fs_monitor_pin_out, ctrl[0] ? cv[2] : cv[0] & ~cv[1]);
      chk("duty", {interrupt_pin_out, clock_switch_window_pin_out}, cv[5:4]);
      chk("aud", channel_status_pin_out, cv[3]);
      chk("err", lock_or_data_error_flag, cv[6] | cv[7]);
      chk("sel", {master_clock_out, bit_clock_out, lr_clock_out, serial_data_out}, ctrl[3] ? g : cv[11:8]);
      chk("osc", oscillator_clock_output, oscillator_input);
      chk("gpoe", gpio_oe_b, 4'hF);
      chk("gpo", gpio_out, ctrl[7:4]);
      axr(OFS_FS);
      chk("fs", rd, (fs_khz_in >= 8'h20 && fs_khz_in <= 8'hC0) ? fs_khz_in : 8'h0);
    end
    sync_pattern_found_in <= 1'h1;
    @(posedge clk);
    sync_pattern_found_in <= 1'h0;
    repeat (3) @(posedge clk);
    axr(OFS_STAT);
    chk("det", {stream_detect, rd[5]}, 2'h3);
    axw(OFS_STAT, 32'h20);
    repeat (2) @(posedge clk);
    chk("clr", stream_detect, 1'h0);
    // host write then read back over the serial port
    ctrl = xs();
    i_aps_host_mcu.xfer({1'h0, ctrl[3:0], ctrl[15:8]}, q, oe);
    i_aps_host_mcu.xfer({1'h1, ctrl[3:0], 8'h0}, q, oe);
    chk("hread", {host_read_oe_b, oe, q}, {2'h2, ctrl[15:8]});
    // software rewrites that word; the host must then read the new byte
    s_wstrb <= 4'h2;
    axw(OFS_CMD, {16'h0, ~ctrl[15:8], 4'h0, ctrl[3:0]});
    axr(OFS_CMD);
    chk("cmd", {rd[15:8], rd[3:0]}, {~ctrl[15:8], ctrl[3:0]});
    i_aps_host_mcu.xfer({1'h1, ctrl[3:0], 8'h0}, q, oe);
    chk("hread2", {oe, q}, {1'h0, ~ctrl[15:8]});
    // unmapped place answers with an error and no data
    axw(8'h10, 32'hFFFF);
    chk("uw", rr, RESP_SLVERR);
    axr(8'h10);
    chk("ur", {rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
    print_verdict();
  end
endmodule
